// [hdl/lbb_defs.svh]
// Purpose: Constants for the LED bank brightness block: offsets, fields, resets, timing.
// Assumes: 25 MHz reference clock.
// Notes:   Definitions only; included by bare name.
`ifndef LBB_DEFS_SVH
`define LBB_DEFS_SVH

// ==========================================================
// Serial bus identity
// ==========================================================
// Device bus address (arbitrary value)
`define LBB_DEV_ADDR        7'h2A

// ==========================================================
// Register offsets
// ==========================================================
`define LBB_RA_SINK_MAP     8'h10
`define LBB_RA_ST_SD_RAMP   8'h11
`define LBB_RA_RUN_RAMP     8'h12
`define LBB_RA_DUTY_CFG0    8'h13
`define LBB_RA_BRIGHT_CFG0  8'h16
`define LBB_RA_FULL_SCALE0  8'h19
`define LBB_RA_BANK_ENABLE  8'h1D
`define LBB_RA_LEVEL0       8'h1F
`define LBB_RA_ZONE0        8'h60
`define LBB_NUM_ZONE_REGS   15

// ==========================================================
// Field positions
// ==========================================================
`define LBB_F_LINEAR        1
`define LBB_F_ZSEL_HI       4
`define LBB_F_ZSEL_LO       2
`define LBB_F_DUTY_SEL      0
`define LBB_F_GATE_LO       2
`define LBB_F_RATE_A_LO     0
`define LBB_F_RATE_B_LO     3

// ==========================================================
// Reset values
// ==========================================================
`define LBB_RST_SINK_MAP    8'h24
`define LBB_RST_FULL_SCALE  8'h13
`define LBB_RST_ZERO        8'h00

// ==========================================================
// Timing
// ==========================================================
`define LBB_CLK_NS          40
`define LBB_RAMP_BASE_NS    2048
`define LBB_RAMP_BASE_CYC   ((`LBB_RAMP_BASE_NS + `LBB_CLK_NS - 1) / `LBB_CLK_NS)
`define LBB_DUTY_WINDOW     8'hFE

`endif

// [hdl/lbb_pkg.sv]
// Purpose: Shared types of the LED bank brightness block.
// Assumes: Constants live in lbb_defs.svh.
// Notes:   Types only.
package lbb_pkg;

  // ==========================================================
  // Serial slave states
  // ==========================================================
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_PTR, I_WR, I_ACK, I_RD, I_RACK} lbb_i2c_e;

  // Register write carried from the serial slave to the register file
  typedef struct packed {
    logic       stb;
    logic [7:0] addr;
    logic [7:0] data;
  } lbb_reg_wr_s;

endpackage

// [hdl/lbb_serial_slave.sv]
// Purpose: Two-wire serial slave giving byte access to the register file.
// Assumes: scl_in and sda_in already synchronous to ref_clk.
// Notes:   Pointer auto-increments on each data byte, read or write.
`timescale 1ns/1ps
`include "lbb_defs.svh"

module lbb_serial_slave
  import lbb_pkg::*;
(
  // Clock and control
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // Bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Register side
  output lbb_reg_wr_s      reg_wr,
  output logic [7:0]       rd_addr,
  input  wire logic [7:0]  rd_data
);

  lbb_i2c_e   state;   // Protocol phase
  lbb_i2c_e   after;   // Phase following the ack slot
  logic       scl_q;   // Previous clock level
  logic       sda_q;   // Previous data level
  logic [7:0] shreg;   // Shift register
  logic [2:0] bitcnt;  // Bit counter, wraps each byte
  logic       got;     // Full byte received

  // ==========================================================
  // Edge and condition detection
  // ==========================================================
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_c  = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_c   = scl_in & scl_q & ~sda_q & sda_in;
  wire rx_state = (state == I_ADDR) || (state == I_PTR) || (state == I_WR);

  assign rd_addr = reg_wr.addr;

  // Protocol engine; data changes only on falling clock edges
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state   <= I_IDLE;
      after   <= I_IDLE;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      shreg   <= 8'h00;
      bitcnt  <= 3'h0;
      got     <= 1'b0;
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
      reg_wr  <= '0;
    end
    else if (clk_en)
    begin
      scl_q      <= scl_in;
      sda_q      <= sda_in;
      reg_wr.stb <= 1'b0;
      // Start restarts any phase, including a repeated start
      if (start_c)
      begin
        state  <= I_ADDR;
        bitcnt <= 3'h0;
        got    <= 1'b0;
        sda_oe <= 1'b0;
      end
      else if (stop_c)
      begin
        state  <= I_IDLE;
        sda_oe <= 1'b0;
      end
      else if (rx_state)
      begin
        // Sample on rising edge
        if (scl_rise)
        begin
          shreg  <= {shreg[6:0], sda_in};
          bitcnt <= bitcnt + 3'h1;
          got    <= (bitcnt == 3'h7);
        end
        else if (scl_fall && got)
        begin
          got    <= 1'b0;
          sda_oe <= 1'b1;
          state  <= I_ACK;
          if (state == I_ADDR)
          begin
            // Foreign address: stay silent
            if (shreg[7:1] != `LBB_DEV_ADDR)
            begin
              state  <= I_IDLE;
              sda_oe <= 1'b0;
            end
            after <= shreg[0] ? I_RD : I_PTR;
          end
          else if (state == I_PTR)
          begin
            reg_wr.addr <= shreg;
            after       <= I_WR;
          end
          else
          begin
            reg_wr.stb  <= 1'b1;
            reg_wr.data <= shreg;
            after       <= I_WR;
          end
        end
      end
      else if (state == I_ACK)
      begin
        // Release ack, or load the first read bit
        if (scl_fall)
        begin
          sda_oe <= 1'b0;
          state  <= after;
          bitcnt <= 3'h0;
          if (after == I_RD)
          begin
            shreg  <= rd_data;
            sda_oe <= ~rd_data[7];
          end
        end
        // Pointer holds here; it already moved one cycle after the write strobe
        if (scl_rise && after == I_WR && reg_wr.stb == 1'b0 && bitcnt == 3'h0 && !got)
          reg_wr.addr <= reg_wr.addr;
      end
      else if (state == I_RD)
      begin
        if (scl_fall)
        begin
          bitcnt <= bitcnt + 3'h1;
          shreg  <= {shreg[6:0], 1'b0};
          sda_oe <= ~shreg[6];
          if (bitcnt == 3'h7)
          begin
            sda_oe      <= 1'b0;
            state       <= I_RACK;
            reg_wr.addr <= reg_wr.addr + 8'h01;
          end
        end
      end
      else if (state == I_RACK)
      begin
        // Master nack ends the read
        if (scl_rise)
        begin
          state <= sda_in ? I_IDLE : I_ACK;
          after <= I_RD;
        end
      end
      // Advance pointer one cycle after a write strobe
      if (reg_wr.stb)
        reg_wr.addr <= reg_wr.addr + 8'h01;
    end
  end

endmodule

// [hdl/lbb_top.sv]
// Purpose: LED bank brightness control: three banks, three sinks, ramps, mapping, duty gating.
// Assumes: All inputs synchronous to ref_clk; sys_rst synchronous, active high.
// Notes:   Sink outputs are 16-bit fractions of the largest sink current.
//
// Functional notes
// - Ramp startup, shutdown, step-up, step-down separately
// - Eight startup and shutdown rates, shared by banks
// - Eight run-time up and down rates, shared
// - Brightness code is 8 bits, full-scale fraction
// - Config bit 1 picks linear or exponential
// - Exponential: 0.85 power law times duty
// - Linear: code over 255 times duty
// - Register-direct control; ambient sensing lives elsewhere
// - Config bits 4:2 pick zone target register
// - Duty config bit 0 picks duty input
// - Duty bits 6:2 gate per zone target
// - Gated current combines code and measured duty
// - Map fields place sinks; 00 means bank A
// - Bank enable bits switch their mapped sinks
// - Global enable low resets all registers
// - Per-bank full-scale setting, 32 values
`timescale 1ns/1ps
`include "lbb_defs.svh"

module lbb_top
  import lbb_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        global_enable_pin,
  // Serial bus
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Duty-cycle inputs
  input  wire logic        duty_input_one,
  input  wire logic        duty_input_two,
  // Sink current commands
  output logic [15:0]      sink_one,
  output logic [15:0]      sink_two,
  output logic [15:0]      sink_three
);

  // ==========================================================
  // Reset and register storage
  // ==========================================================
  // shutdown clears state
  wire         rst = sys_rst | ~global_enable_pin;

  lbb_reg_wr_s reg_wr;                            // Write from serial slave
  logic [7:0]  rd_addr;                           // Read pointer
  logic [7:0]  rd_data;                           // Read data
  logic [7:0]  sink_bank_mapping;                 // Sink to bank fields
  logic [7:0]  st_sd_ramp;                        // Startup/shutdown rates
  logic [7:0]  run_ramp;                          // Run-time rates
  logic [7:0]  bank_enable;                       // Bank enables
  logic [7:0]  duty_cfg   [3];                    // Per-bank duty config
  logic [7:0]  bright_cfg [3];                    // Per-bank brightness config
  logic [7:0]  full_scale [3];                    // Per-bank full scale
  logic [7:0]  zone_tgt   [`LBB_NUM_ZONE_REGS];   // Zone targets, bank*5+zone
  logic [7:0]  bank_level [3];                    // Ramped codes, for readback
  logic [15:0] bank_cur   [3];                    // Mapped bank currents
  logic [8:0]  duty_meas  [2];                    // Measured duty, 256 = full

  // ==========================================================
  // Serial slave
  // ==========================================================
  lbb_serial_slave u_slave (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .reg_wr  (reg_wr),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // ==========================================================
  // Register decode
  // ==========================================================
  wire [7:0] zone_idx = reg_wr.addr - `LBB_RA_ZONE0;
  wire [7:0] rzone    = rd_addr - `LBB_RA_ZONE0;
  wire [7:0] rduty    = rd_addr - `LBB_RA_DUTY_CFG0;
  wire [7:0] rbright  = rd_addr - `LBB_RA_BRIGHT_CFG0;
  wire [7:0] rfs      = rd_addr - `LBB_RA_FULL_SCALE0;
  wire [7:0] rlvl     = rd_addr - `LBB_RA_LEVEL0;

  // Read mux; unmapped offsets read zero
  assign rd_data =
    (rd_addr == `LBB_RA_SINK_MAP)    ? sink_bank_mapping :
    (rd_addr == `LBB_RA_ST_SD_RAMP)  ? st_sd_ramp :
    (rd_addr == `LBB_RA_RUN_RAMP)    ? run_ramp :
    (rd_addr == `LBB_RA_BANK_ENABLE) ? bank_enable :
    (rduty < 8'd3)                   ? duty_cfg[rduty[1:0]] :
    (rbright < 8'd3)                 ? bright_cfg[rbright[1:0]] :
    (rfs < 8'd3)                     ? full_scale[rfs[1:0]] :
    (rlvl < 8'd3)                    ? bank_level[rlvl[1:0]] :
    (rzone < 8'd15)                  ? zone_tgt[rzone[3:0]] : 8'h00;

  // Register writes; bank registers use a per-bank offset
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sink_bank_mapping <= `LBB_RST_SINK_MAP;
      st_sd_ramp        <= `LBB_RST_ZERO;
      run_ramp          <= `LBB_RST_ZERO;
      bank_enable       <= `LBB_RST_ZERO;
      for (int i = 0; i < 3; i++)
      begin
        duty_cfg[i]   <= `LBB_RST_ZERO;
        bright_cfg[i] <= `LBB_RST_ZERO;
        full_scale[i] <= `LBB_RST_FULL_SCALE;
      end
      for (int z = 0; z < `LBB_NUM_ZONE_REGS; z++)
        zone_tgt[z] <= `LBB_RST_ZERO;
    end
    else if (clk_en && reg_wr.stb)
    begin
      if (reg_wr.addr == `LBB_RA_SINK_MAP)
        sink_bank_mapping <= reg_wr.data;
      if (reg_wr.addr == `LBB_RA_ST_SD_RAMP)
        st_sd_ramp <= reg_wr.data;
      if (reg_wr.addr == `LBB_RA_RUN_RAMP)
        run_ramp <= reg_wr.data;
      if (reg_wr.addr == `LBB_RA_BANK_ENABLE)
        bank_enable <= reg_wr.data;
      for (int i = 0; i < 3; i++)
      begin
        if (reg_wr.addr == `LBB_RA_DUTY_CFG0 + 8'(i))
          duty_cfg[i] <= reg_wr.data;
        if (reg_wr.addr == `LBB_RA_BRIGHT_CFG0 + 8'(i))
          bright_cfg[i] <= reg_wr.data;
        if (reg_wr.addr == `LBB_RA_FULL_SCALE0 + 8'(i))
          full_scale[i] <= {3'h0, reg_wr.data[4:0]};
      end
      if (zone_idx < 8'd15)
        zone_tgt[zone_idx[3:0]] <= reg_wr.data;
    end
  end

  // ==========================================================
  // Duty measurement over a fixed window
  // ==========================================================
  logic [7:0] win_cnt;   // Window position
  wire        win_end = (win_cnt == `LBB_DUTY_WINDOW);

  // Window counter, 255 samples per window
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      win_cnt <= 8'h00;
    else if (clk_en)
      win_cnt <= win_end ? 8'h00 : win_cnt + 8'h01;
  end

  genvar d;
  generate
    for (d = 0; d < 2; d++)
    begin : g_duty
      logic [7:0] hi_cnt;   // High samples in window
      wire        din = (d == 0) ? duty_input_one : duty_input_two;
      // Count high samples; each window starts from zero so none is counted twice
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          hi_cnt       <= 8'h00;
          duty_meas[d] <= 9'h100;
        end
        else if (clk_en)
        begin
          hi_cnt <= win_end ? 8'h00 : hi_cnt + {7'h00, din};
          // Scale 0..255 to 0..256 so full duty is exact
          if (win_end)
            duty_meas[d] <= {1'b0, hi_cnt + {7'h00, din}} + {8'h00, hi_cnt[7]};
        end
      end
    end
  endgenerate

  // ==========================================================
  // Ramp timebase
  // ==========================================================
  logic [11:0] pre_cnt;    // Base period prescaler
  logic [7:0]  tick_cnt;   // Base ticks, sets rate divisions
  wire         base_tick = (pre_cnt == 12'(`LBB_RAMP_BASE_CYC - 1));

  // Shared by all banks so equal rates move in step
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pre_cnt  <= 12'h000;
      tick_cnt <= 8'h00;
    end
    else if (clk_en)
    begin
      pre_cnt <= base_tick ? 12'h000 : pre_cnt + 12'h001;
      if (base_tick)
        tick_cnt <= tick_cnt + 8'h01;
    end
  end

  // Exponential mantissas, 2^(-f/8) scaled to 16 bits
  localparam logic [15:0] EXP_MANT [8] = '{16'hFFFF, 16'hEAC1, 16'hD745, 16'hC567,
                                           16'hB505, 16'hA5FF, 16'h9838, 16'h8B96};

  // ==========================================================
  // Per-bank target, ramp and mapping
  // ==========================================================
  genvar b;
  generate
    for (b = 0; b < 3; b++)
    begin : g_bank
      logic [7:0]  level;      // Ramped code
      logic        starting;   // In startup ramp
      wire  [2:0]  zsel  = bright_cfg[b][`LBB_F_ZSEL_HI] ? 3'd4 : {1'b0, bright_cfg[b][3:2]};
      wire  [7:0]  code  = zone_tgt[b * 5 + zsel];
      wire  [7:0]  goal  = bank_enable[b] ? code : 8'h00;
      wire         gate  = duty_cfg[b][`LBB_F_GATE_LO + zsel];
      wire  [8:0]  duty  = !gate ? 9'h100 :
                           duty_cfg[b][`LBB_F_DUTY_SEL] ? duty_meas[1] : duty_meas[0];
      wire         up    = goal > level;
      wire  [2:0]  rate  = (goal == 8'h00) ? st_sd_ramp[`LBB_F_RATE_A_LO +: 3] :
                           (starting || level == 8'h00) ? st_sd_ramp[`LBB_F_RATE_B_LO +: 3] :
                           up              ? run_ramp[`LBB_F_RATE_B_LO +: 3] :
                                             run_ramp[`LBB_F_RATE_A_LO +: 3];
      wire  [7:0]  rmask = (8'h01 << rate) - 8'h01;
      wire         step  = base_tick && ((tick_cnt & rmask) == 8'h00) && (goal != level);
      // exponent (255-code)*75/2048 as base-2 shift and fraction
      wire  [14:0] ex    = 15'(8'hFF - level) * 15'd75;
      wire  [15:0] efrac = EXP_MANT[ex[10:8]] >> ex[14:11];
      // linear code*257 equals code/255 of full
      wire  [15:0] frac  = bright_cfg[b][`LBB_F_LINEAR] ? {level, level} : efrac;
      wire  [21:0] fsv   = 22'(frac) * 22'(full_scale[b][4:0] + 6'h01);
      wire  [24:0] cur   = 25'(fsv[20:5]) * 25'(duty);

      assign bank_level[b] = level;

      // Step one code per rate tick toward the goal
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          level    <= 8'h00;
          starting <= 1'b0;
          bank_cur[b] <= 16'h0000;
        end
        else if (clk_en)
        begin
          // Startup ends once the first target is reached
          if (level == 8'h00 && goal != 8'h00)
            starting <= 1'b1;
          else if (level == goal)
            starting <= 1'b0;
          if (step)
            level <= up ? level + 8'h01 : level - 8'h01;
          // Zero code is fully off in either mode
          bank_cur[b] <= (level == 8'h00) ? 16'h0000 : cur[23:8];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Sink routing
  // ==========================================================
  // pick bank per sink field; 11 leaves sink off
  wire [15:0] route [3];
  genvar s;
  generate
    for (s = 0; s < 3; s++)
    begin : g_sink
      wire [1:0] m = sink_bank_mapping[2 * s +: 2];
      assign route[s] = (m == 2'b11) ? 16'h0000 : bank_cur[m];
    end
  endgenerate

  // Registered sink commands
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sink_one   <= 16'h0000;
      sink_two   <= 16'h0000;
      sink_three <= 16'h0000;
    end
    else if (clk_en)
    begin
      sink_one   <= route[0];
      sink_two   <= route[1];
      sink_three <= route[2];
    end
  end

endmodule

// [tb/lbb_host_model.sv]
// Purpose: Bus master model standing in for the host processor.
// Assumes: Pull-up on SDA; lines change just after ref_clk falls.
// Notes:   Counts unanswered write bytes in nacks.
`timescale 1ns/1ps
`include "lbb_defs.svh"

module lbb_host_model (
  // Clock
  input  wire logic ref_clk,
  // Bus lines
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_wire
);
  // ====================
  // Bit level
  // ====================
  int nacks = 0; // Bytes left without ack

  // Idle bus: both lines released
  initial scl = 1'b1;
  initial sda_drv = 1'b1;

  // Wait n falling edges
  task automatic hold(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Data set in SCL low, sampled late in SCL high
  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    hold(4);
    scl = 1'b1;
    hold(4);
    s = sda_wire;
    scl = 1'b0;
    hold(1);
  endtask

  // Start or repeated start
  task automatic start();
    sda_drv = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda_drv = 1'b0;
    hold(4);
    scl = 1'b0;
    hold(1);
  endtask

  // Stop: SDA rises while SCL high
  task automatic stop();
    sda_drv = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda_drv = 1'b1;
    hold(4);
  endtask

  // One byte MSB first, ninth bit released (ack slot or final nack)
  task automatic xfer(input logic [7:0] tx, input logic want_ack, output logic [7:0] rx);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(1'b1, s);
    // A write byte with no ack means the device refused it
    if (want_ack && s !== 1'b0)
      nacks++;
  endtask

  // Register write: address, pointer, data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({`LBB_DEV_ADDR, 1'b0}, 1'b1, r);
    xfer(a, 1'b1, r);
    xfer(d, 1'b1, r);
    stop();
  endtask

  // Register read: pointer write, repeated start, one byte
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({`LBB_DEV_ADDR, 1'b0}, 1'b1, r);
    xfer(a, 1'b1, r);
    start();
    xfer({`LBB_DEV_ADDR, 1'b1}, 1'b1, r);
    xfer(8'hFF, 1'b0, d);
    stop();
  endtask
endmodule

// [tb/lbb_top_chk.sv]
// Purpose: Port-level assertions for lbb_top.
// Assumes: One clock; sys_rst synchronous, active high.
// Notes:   Bound into every lbb_top instance.
`timescale 1ns/1ps

module lbb_top_chk (
  // Clock and control
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic        global_enable_pin,
  // Serial bus
  input wire logic        scl_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  // Sink commands
  input wire logic [15:0] sink_one,
  input wire logic [15:0] sink_two,
  input wire logic [15:0] sink_three
);
  // ====================
  // Helpers
  // ====================
  logic all_off; // Every sink commanded off
  assign all_off = (sink_one == 16'h0000) && (sink_two == 16'h0000) && (sink_three == 16'h0000);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ====================
  // Assertions
  // ====================
  property p_rst_clears; $fell(sys_rst) |-> (!sda_oe) [*8]; endproperty
  a_rst_clears: assert property (p_rst_clears) else $error("sda driven after reset");
  property p_pin_clears; !global_enable_pin && clk_en |=> all_off && !sda_oe; endproperty
  a_pin_clears: assert property (p_pin_clears) else $error("enable pin low did not clear");
  // Banks start disabled, so nothing lights before a bus write
  property p_idle; $fell(sys_rst) |-> all_off [*8]; endproperty
  a_idle: assert property (p_idle) else $error("sink on after reset");
  property p_freeze; !clk_en |=> $stable(sink_one) && $stable(sink_two) && $stable(sink_three); endproperty
  a_freeze: assert property (p_freeze) else $error("ramp moved while frozen");
  property p_open_drain; sda_out == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");
  // Changing SDA in SCL high would fake a start or stop
  property p_oe_edge; $changed(sda_oe) && $past(global_enable_pin) |-> !$past(scl_in); endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("sda moved in scl high");
  property p_oe_holds; disable iff (sys_rst || !global_enable_pin) $rose(sda_oe) |-> sda_oe [*4]; endproperty
  a_oe_holds: assert property (p_oe_holds) else $error("sda pull too short");
  property p_ack_win; disable iff (sys_rst || !global_enable_pin) $rose(sda_oe) |-> !scl_in ##1 !scl_in; endproperty
  a_ack_win: assert property (p_ack_win) else $error("sda pulled late");
endmodule

bind lbb_top lbb_top_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .global_enable_pin(global_enable_pin), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .sink_one(sink_one), .sink_two(sink_two), .sink_three(sink_three));

// [tb/tb_top.sv]
// Purpose: Self-checking bench for lbb_top.
// Assumes: 25 MHz clock; inputs change after falling edges.
// Notes:   Duty input one held low, two held high.
`timescale 1ns/1ps
`include "lbb_defs.svh"

module tb_top;
  // ====================
  // Signals
  // ====================
  localparam int TICK = `LBB_RAMP_BASE_CYC; // Ramp base tick in cycles
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        global_enable_pin = 1'b1;
  logic        duty_input_one = 1'b0;
  logic        duty_input_two = 1'b1;
  logic        scl;
  logic        sda_drv;
  logic        sda_out;
  logic        sda_oe;
  logic [15:0] sink_one;
  logic [15:0] sink_two;
  logic [15:0] sink_three;
  logic [7:0]  rv;
  logic [7:0]  duty_cfg [3] = '{8'h05, 8'h04, 8'h08}; // Input two gated, input one gated, other zone gated
  logic [15:0] duty_exp [3] = '{16'hFFFF, 16'h0000, 16'hFFFF};
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  wire         sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1); // Open drain with pull-up

  always #20 ref_clk = ~ref_clk;

  lbb_top uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .global_enable_pin(global_enable_pin),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .duty_input_one(duty_input_one),
    .duty_input_two(duty_input_two), .sink_one(sink_one), .sink_two(sink_two), .sink_three(sink_three));
  lbb_host_model host (.ref_clk(ref_clk), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));

  // ====================
  // Checking tasks
  // ====================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // Cycles until sink_one reaches v, bounded past the window
  task automatic wait_one(input logic [15:0] v, input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] n;
    n = 0;
    while (sink_one !== v && n < hi + 200)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk_in(n, lo, hi);
  endtask

  task automatic final_report();
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard, well above the expected run
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      num_errors++;
      final_report();
    end
  end

  // ====================
  // Sequence
  // ====================
  initial
  begin
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    host.rd(`LBB_RA_SINK_MAP, rv);
    chk(rv, `LBB_RST_SINK_MAP);
    host.rd(`LBB_RA_BANK_ENABLE, rv);
    chk(rv, `LBB_RST_ZERO);
    host.wr(`LBB_RA_FULL_SCALE0, 8'hFF);
    host.rd(`LBB_RA_FULL_SCALE0, rv);
    chk(rv, 8'h1F);
    host.wr(`LBB_RA_ST_SD_RAMP, 8'h08);
    host.wr(`LBB_RA_RUN_RAMP, 8'h10);
    host.rd(`LBB_RA_RUN_RAMP, rv);
    chk(rv, 8'h10);
    host.wr(`LBB_RA_ZONE0, 8'hFF);
    host.wr(`LBB_RA_ZONE0 + 8'h04, 8'h80);
    host.wr(`LBB_RA_BRIGHT_CFG0, 8'h02);
    host.wr(`LBB_RA_BANK_ENABLE, 8'h01);
    // Startup at rate 1: two ticks per code
    wait_one(16'hFFFF, 255 * 2 * TICK - 200, 255 * 2 * TICK + 200);
    chk(sink_two, 16'h0000);
    host.rd(`LBB_RA_LEVEL0, rv);
    chk(rv, 8'hFF);
    // Sink one to bank B, two to C, three to A
    host.wr(`LBB_RA_SINK_MAP, 8'h09);
    repeat (4) @(negedge ref_clk);
    chk(sink_one, 16'h0000);
    chk(sink_two, 16'h0000);
    chk(sink_three, 16'hFFFF);
    host.wr(`LBB_RA_SINK_MAP, `LBB_RST_SINK_MAP);
    // Duty selection and per-zone gating; over two windows each
    for (int i = 0; i < 3; i++)
    begin
      host.wr(`LBB_RA_DUTY_CFG0, duty_cfg[i]);
      repeat (600) @(negedge ref_clk);
      chk(sink_one, duty_exp[i]);
    end
    // Select 1XX: zone target 4, run-time down rate 0
    host.wr(`LBB_RA_BRIGHT_CFG0, 8'h12);
    wait_one(16'h8080, 127 * TICK - 150, 127 * TICK + 150);
    host.wr(`LBB_RA_BRIGHT_CFG0, 8'h10);
    repeat (4) @(negedge ref_clk);
    chk_in(sink_one, 32'h0800, 32'h0C00);
    // Step up four codes at run-time up rate 2: four ticks per code
    host.wr(`LBB_RA_BRIGHT_CFG0, 8'h12);
    host.wr(`LBB_RA_ZONE0 + 8'h04, 8'h84);
    wait_one(16'h8484, 12 * TICK - 50, 16 * TICK);
    // Shutdown with a freeze in mid-ramp
    host.wr(`LBB_RA_BANK_ENABLE, 8'h00);
    repeat (1000) @(negedge ref_clk);
    clk_en = 1'b0;
    repeat (100) @(negedge ref_clk);
    clk_en = 1'b1;
    wait_one(16'h0000, 132 * TICK - 1150, 132 * TICK - 850);
    global_enable_pin = 1'b0;
    repeat (2) @(negedge ref_clk);
    global_enable_pin = 1'b1;
    @(negedge ref_clk);
    host.rd(`LBB_RA_FULL_SCALE0, rv);
    chk(rv, `LBB_RST_FULL_SCALE);
    host.rd(`LBB_RA_BRIGHT_CFG0, rv);
    chk(rv, `LBB_RST_ZERO);
    chk(host.nacks, 0);
    final_report();
  end
endmodule
